/* rtl/tmc_consts.svh */
/*
  Register offsets, field positions, reset values and prescaler taps for
  the timer channel mode configuration block.
  Assumes one 100 MHz system clock and an APB bus with 32-bit data.
*/
// Summary of operation
// - Channel 2 clock select: div 1,4,16,64, pins A,B,C, then div 1024.
// - Channel 2 clock select ignored while channel 2 is phase counting.
// - Channels 3,4 select: div 1,4,16,64,256,1024, then pins A and B.
// - Every clock select field resets to 000; channel 4 reads back only its bits 1-0.
// - Five eight-bit mode registers, reset to c0, kept over manual reset.
// - Mode bits 7 and 6 always read one; writes ignored.
// - Bit 5 set on channels 0,3,4 pairs B with D; D raises no events.
// - Bit 4 set on channels 0,3,4 pairs A with C; C raises no events.
// - Channels 1,2 pairing bits read zero and cannot be written.
// - Mode 0000 normal, 0010/0011 PWM 1/2, 0100-0111 phase count 1-4.
// - Mode 1000 reset-sync PWM; 1101/1110/1111 complementary PWM.
// - Channel 3 in reset-sync or complementary PWM drives channel 4.
// - Eight I/O control registers, cleared to 00, kept over manual reset.
// - First I/O register: bits 7-4 code for B, bits 3-0 for A.
// - Second I/O register: bits 7-4 code for D, bits 3-0 for C.
// - C or D in buffer pairing ignores its I/O code, except the initial level bit.
// - I/O code: output compare kinds, initial level, or capture edges.
`ifndef TMC_CONSTS_SVH
`define TMC_CONSTS_SVH

// Byte offsets, one word each
`define TMC_OFS_MODE0      12'h000
`define TMC_OFS_MODE1      12'h004
`define TMC_OFS_MODE2      12'h008
`define TMC_OFS_MODE3      12'h00c
`define TMC_OFS_MODE4      12'h010
`define TMC_OFS_IOAB0      12'h020
`define TMC_OFS_IOAB1      12'h024
`define TMC_OFS_IOAB2      12'h028
`define TMC_OFS_IOAB3      12'h02c
`define TMC_OFS_IOAB4      12'h030
`define TMC_OFS_IOCD0      12'h040
`define TMC_OFS_IOCD3      12'h044
`define TMC_OFS_IOCD4      12'h048
`define TMC_OFS_CKSEL      12'h060
`define TMC_OFS_STATUS     12'h064

// Field positions
`define TMC_BIT_BUF_B      5
`define TMC_BIT_BUF_A      4

// Reset values
`define TMC_MODE_RESET     8'hc0
`define TMC_MODE_FIXED     8'hc0
`define TMC_IO_RESET       8'h00
`define TMC_CKSEL_RESET    3'h0

// Prescaler taps (bit index of a 10-bit free-running count)
`define TMC_PRE_W          10
`define TMC_TAP_4          1
`define TMC_TAP_16         3
`define TMC_TAP_64         5
`define TMC_TAP_256        7
`define TMC_TAP_1024       9

`endif

/* rtl/tmc_pkg.sv */
/*
  Types for the timer channel mode configuration block.
  Assumes tmc_consts.svh is included by the design that uses it.
*/
package tmc_pkg;

  // Decoded operating mode of one channel
  typedef enum logic [3:0] {
    TMC_NORMAL,
    TMC_PWM1,
    TMC_PWM2,
    TMC_PHASE1,
    TMC_PHASE2,
    TMC_PHASE3,
    TMC_PHASE4,
    TMC_RSYNC_PWM,
    TMC_CPWM_PEAK,
    TMC_CPWM_VALLEY,
    TMC_CPWM_BOTH,
    TMC_RESERVED
  } tmc_mode_t;

  // Decoded function of one general register
  typedef enum logic [2:0] {
    TMC_IO_OFF,
    TMC_IO_OUT0,
    TMC_IO_OUT1,
    TMC_IO_TOGGLE,
    TMC_IO_CAP_RISE,
    TMC_IO_CAP_FALL,
    TMC_IO_CAP_BOTH,
    TMC_IO_BUFFER
  } tmc_io_t;

endpackage

/* rtl/tmc_channel_cfg.sv */
/*
  Mode, I/O control and clock select registers of a five-channel timer,
  with the count-pulse selection for channels 2, 3 and 4 and the decoded
  per-register functions handed to the counter core.
  Assumes an APB master on clk_sys, external count pins asynchronous to
  clk_sys, and a counter core that consumes the decoded outputs.
  reset_n stands for power-on reset or standby entry; a manual reset must
  not be routed here, so the registers keep their values through it.
*/
`include "tmc_consts.svh"

module tmc_channel_cfg
  import tmc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // External count pins
  input  wire logic        ext_count_pin_a,
  input  wire logic        ext_count_pin_b,
  input  wire logic        ext_count_pin_c,
  // Count pulses to the counter core, channels 2 to 4
  output logic      [2:0]  count_tick,
  // Decoded channel modes (channel 4 follows channel 3 when ganged)
  output tmc_mode_t        mode_ch [5],
  // Decoded register functions, A to D per channel
  output tmc_io_t          func_a [5],
  output tmc_io_t          func_b [5],
  output tmc_io_t          func_c [5],
  output tmc_io_t          func_d [5],
  // Initial pin level for output compare, A to D per channel
  output logic      [4:0]  init_lvl_a,
  output logic      [4:0]  init_lvl_b,
  output logic      [4:0]  init_lvl_c,
  output logic      [4:0]  init_lvl_d
);

  // ************************************************************
  // Decoding functions
  // ************************************************************
  function automatic tmc_mode_t dec_mode(input logic [3:0] code);
    unique case (code)
      4'h0:    dec_mode = TMC_NORMAL;
      4'h2:    dec_mode = TMC_PWM1;
      4'h3:    dec_mode = TMC_PWM2;
      4'h4:    dec_mode = TMC_PHASE1;
      4'h5:    dec_mode = TMC_PHASE2;
      4'h6:    dec_mode = TMC_PHASE3;
      4'h7:    dec_mode = TMC_PHASE4;
      4'h8:    dec_mode = TMC_RSYNC_PWM;
      4'hd:    dec_mode = TMC_CPWM_PEAK;
      4'he:    dec_mode = TMC_CPWM_VALLEY;
      4'hf:    dec_mode = TMC_CPWM_BOTH;
      default: dec_mode = TMC_RESERVED;
    endcase
  endfunction

  function automatic tmc_io_t dec_io(input logic [3:0] code,
                                     input logic       buffered);
    if (buffered) begin
      dec_io = TMC_IO_BUFFER;
    end else if (!code[3]) begin
      unique case (code[1:0])
        2'h0: dec_io = TMC_IO_OFF;
        2'h1: dec_io = TMC_IO_OUT0;
        2'h2: dec_io = TMC_IO_OUT1;
        2'h3: dec_io = TMC_IO_TOGGLE;
      endcase
    end else begin
      unique case (code[1:0])
        2'h0:    dec_io = TMC_IO_CAP_RISE;
        2'h1:    dec_io = TMC_IO_CAP_FALL;
        default: dec_io = TMC_IO_CAP_BOTH;
      endcase
    end
  endfunction

  function automatic logic is_gang(input logic [3:0] code);
    is_gang = (code == 4'h8) || (code >= 4'hd);
  endfunction

  // ************************************************************
  // Registers
  // ************************************************************
  logic [5:0] mode_q [5];
  logic [7:0] io_ab_q [5];
  logic [7:0] io_cd_q [5];
  logic [2:0] cksel_q [3];
  logic [2:0] pin_a_q, pin_b_q, pin_c_q;
  logic [2:0] pin_lvl_q;
  logic [`TMC_PRE_W-1:0] pre_q;
  logic [5:0] tap_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;

  // APB decode; a write lands only at the edge that completes it
  wire        acc     = psel && !penable;
  wire        wr_set  = psel && penable && pready_q && pwrite && pstrb[0];
  wire [7:0]  wbyte   = pwdata[7:0];
  wire        hit_mode [5];
  wire        hit_ab   [5];
  wire        hit_cd   [5];
  wire        hit_ck   = (paddr == `TMC_OFS_CKSEL);
  wire        hit_st   = (paddr == `TMC_OFS_STATUS);
  localparam logic [11:0] MODE_OFS [5] = '{`TMC_OFS_MODE0, `TMC_OFS_MODE1,
    `TMC_OFS_MODE2, `TMC_OFS_MODE3, `TMC_OFS_MODE4};
  localparam logic [11:0] AB_OFS [5] = '{`TMC_OFS_IOAB0, `TMC_OFS_IOAB1,
    `TMC_OFS_IOAB2, `TMC_OFS_IOAB3, `TMC_OFS_IOAB4};
  localparam logic [11:0] CD_OFS [5] = '{`TMC_OFS_IOCD0, 12'hfff, 12'hfff,
    `TMC_OFS_IOCD3, `TMC_OFS_IOCD4};
  localparam logic FULL [5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};

  // Per-channel read values
  wire [7:0] mode_rd [5];
  wire [7:0] cd_rd   [5];

  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : g_ch
      assign hit_mode[g] = (paddr == MODE_OFS[g]);
      assign hit_ab[g]   = (paddr == AB_OFS[g]);
      assign hit_cd[g]   = FULL[g] && (paddr == CD_OFS[g]);
      // Upper two bits are constant ones
      assign mode_rd[g]  = `TMC_MODE_FIXED | {2'h0, mode_q[g]};
      assign cd_rd[g]    = FULL[g] ? io_cd_q[g] : 8'h00;

      always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
          mode_q[g]  <= 6'(`TMC_MODE_RESET);
          io_ab_q[g] <= `TMC_IO_RESET;
          io_cd_q[g] <= `TMC_IO_RESET;
        end else begin
          if (wr_set && hit_mode[g]) begin
            // Short channels keep pairing bits at zero
            mode_q[g] <= FULL[g] ? wbyte[5:0]
                                 : {2'h0, wbyte[3:0]};
          end
          if (wr_set && hit_ab[g]) begin
            io_ab_q[g] <= wbyte;
          end
          if (wr_set && hit_cd[g]) begin
            io_cd_q[g] <= wbyte;
          end
        end
      end
    end
  endgenerate

  // Clock select: index 0..2 for channels 2..4
  generate
    for (g = 0; g < 3; g++) begin : g_ck
      always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
          cksel_q[g] <= `TMC_CKSEL_RESET;
        end else if (wr_set && hit_ck) begin
          cksel_q[g] <= pwdata[3*g +: 3];
        end
      end
    end
  endgenerate

  // ************************************************************
  // Channel 4 ganging and decoded outputs
  // ************************************************************
  wire       gang34 = is_gang(mode_q[3][3:0]);
  // Channel 4 copies channel 3 settings while ganged
  wire [5:0] mode_eff [5];
  wire [7:0] ab_eff   [5];
  wire [7:0] cd_eff   [5];
  generate
    for (g = 0; g < 5; g++) begin : g_eff
      if (g == 4) begin : g_c4
        assign mode_eff[g] = gang34 ? mode_q[3] : mode_q[4];
        assign ab_eff[g]   = gang34 ? io_ab_q[3] : io_ab_q[4];
        assign cd_eff[g]   = gang34 ? io_cd_q[3] : io_cd_q[4];
      end else begin : g_cn
        assign mode_eff[g] = mode_q[g];
        assign ab_eff[g]   = io_ab_q[g];
        assign cd_eff[g]   = io_cd_q[g];
      end
    end
  endgenerate

  tmc_mode_t mode_d [5];
  tmc_io_t   fa_d [5], fb_d [5], fc_d [5], fd_d [5];
  logic [4:0] la_d, lb_d, lc_d, ld_d;
  generate
    for (g = 0; g < 5; g++) begin : g_dec
      wire buf_b = mode_eff[g][`TMC_BIT_BUF_B];
      wire buf_a = mode_eff[g][`TMC_BIT_BUF_A];
      assign mode_d[g] = dec_mode(mode_eff[g][3:0]);
      assign fa_d[g]   = dec_io(ab_eff[g][3:0], 1'b0);
      assign fb_d[g]   = dec_io(ab_eff[g][7:4], 1'b0);
      // Paired C/D act as buffers only and raise no events
      assign fc_d[g]   = FULL[g] ? dec_io(cd_eff[g][3:0], buf_a)
                                 : TMC_IO_OFF;
      assign fd_d[g]   = FULL[g] ? dec_io(cd_eff[g][7:4], buf_b)
                                 : TMC_IO_OFF;
      assign la_d[g]   = ab_eff[g][2];
      assign lb_d[g]   = ab_eff[g][6];
      assign lc_d[g]   = cd_eff[g][2];
      assign ld_d[g]   = cd_eff[g][6];
    end
  endgenerate

  // ************************************************************
  // Prescaler and count source selection
  // ************************************************************
  // Three-stage synchronisers; a change counts once stages 2 and 3 agree
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      pin_a_q   <= 3'h0;
      pin_b_q   <= 3'h0;
      pin_c_q   <= 3'h0;
      pin_lvl_q <= 3'h0;
    end else begin
      pin_a_q   <= {pin_a_q[1:0], ext_count_pin_a};
      pin_b_q   <= {pin_b_q[1:0], ext_count_pin_b};
      pin_c_q   <= {pin_c_q[1:0], ext_count_pin_c};
      pin_lvl_q <= {pin_c_q[2] == pin_c_q[1] ? pin_c_q[2] : pin_lvl_q[2],
                    pin_b_q[2] == pin_b_q[1] ? pin_b_q[2] : pin_lvl_q[1],
                    pin_a_q[2] == pin_a_q[1] ? pin_a_q[2] : pin_lvl_q[0]};
    end
  end
  wire [2:0] pin_rise = {pin_c_q[2] == pin_c_q[1] && pin_c_q[2]
                           && !pin_lvl_q[2],
                         pin_b_q[2] == pin_b_q[1] && pin_b_q[2]
                           && !pin_lvl_q[1],
                         pin_a_q[2] == pin_a_q[1] && pin_a_q[2]
                           && !pin_lvl_q[0]};

  // One free-running count, so switching taps never makes a runt pulse
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      pre_q <= '0;
      tap_q <= 6'h0;
    end else begin
      pre_q <= pre_q + 1'b1;
      tap_q <= {pre_q[`TMC_TAP_1024], pre_q[`TMC_TAP_256],
                pre_q[`TMC_TAP_64], pre_q[`TMC_TAP_16],
                pre_q[`TMC_TAP_4], 1'b0};
    end
  end
  // Tick on the falling edge of each tap bit: one per divided period
  wire [5:0] tap_now = {pre_q[`TMC_TAP_1024], pre_q[`TMC_TAP_256],
                        pre_q[`TMC_TAP_64], pre_q[`TMC_TAP_16],
                        pre_q[`TMC_TAP_4], 1'b0};
  wire [5:0] div_tick = {tap_q[5:1] & ~tap_now[5:1], 1'b1};

  wire phase2 = (mode_q[2][3:2] == 2'h1);
  wire tick2_sel [8] = '{div_tick[0], div_tick[1], div_tick[2],
    div_tick[3], pin_rise[0], pin_rise[1], pin_rise[2], div_tick[5]};
  wire tick34_sel [8] = '{div_tick[0], div_tick[1], div_tick[2],
    div_tick[3], div_tick[4], div_tick[5], pin_rise[0], pin_rise[1]};
  // Phase counting is clocked by the pins in the core, not by this select
  wire tick2 = phase2 ? 1'b0 : tick2_sel[cksel_q[0]];
  wire tick3 = tick34_sel[cksel_q[1]];
  wire [2:0] ck4 = gang34 ? cksel_q[1] : cksel_q[2];
  wire tick4 = tick34_sel[ck4];

  // ************************************************************
  // Read mux and registered outputs
  // ************************************************************
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    for (int i = 0; i < 5; i++) begin
      if (hit_mode[i]) rd_byte = mode_rd[i];
      if (hit_ab[i])   rd_byte = io_ab_q[i];
      if (hit_cd[i])   rd_byte = cd_rd[i];
    end
    if (hit_ck) rd_byte = {cksel_q[2][1:0], cksel_q[1], cksel_q[0]};
    if (hit_st) rd_byte = {7'h00, gang34};
  end
  logic mapped;
  always_comb begin
    mapped = hit_ck || hit_st;
    for (int i = 0; i < 5; i++) begin
      mapped = mapped || hit_mode[i] || hit_ab[i] || hit_cd[i];
    end
  end

  // No wait state: answer in the cycle after setup
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= acc;
      pslverr_q <= acc && !mapped;
      prdata_q  <= (acc && !pwrite && mapped) ? {24'h0, rd_byte} : 32'h0;
    end
  end
  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      count_tick <= 3'h0;
      init_lvl_a <= 5'h00;
      init_lvl_b <= 5'h00;
      init_lvl_c <= 5'h00;
      init_lvl_d <= 5'h00;
      for (int i = 0; i < 5; i++) begin
        mode_ch[i] <= TMC_NORMAL;
        func_a[i]  <= TMC_IO_OFF;
        func_b[i]  <= TMC_IO_OFF;
        func_c[i]  <= TMC_IO_OFF;
        func_d[i]  <= TMC_IO_OFF;
      end
    end else begin
      count_tick <= {tick4, tick3, tick2};
      init_lvl_a <= la_d;
      init_lvl_b <= lb_d;
      init_lvl_c <= lc_d;
      init_lvl_d <= ld_d;
      for (int i = 0; i < 5; i++) begin
        mode_ch[i] <= mode_d[i];
        func_a[i]  <= fa_d[i];
        func_b[i]  <= fb_d[i];
        func_c[i]  <= fc_d[i];
        func_d[i]  <= fd_d[i];
      end
    end
  end

endmodule

/* verification/tmc_channel_cfg_checker.sv */
/*
  Port checker for the timer channel configuration block.
  Assumes it is bound to tmc_channel_cfg and sees only its ports.
*/
`include "tmc_consts.svh"

module tmc_channel_cfg_checker
  import tmc_pkg::*;
(
  // Clock and reset
  input logic        clk_sys,
  input logic        reset_n,
  // APB slave
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic [3:0]  pstrb,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  // Core side
  input logic [2:0]  count_tick,
  input tmc_mode_t   mode_ch [5],
  input tmc_io_t     func_d [5]
);
  wire mapped = paddr[1:0] == 2'b00 && paddr inside {[12'h000:12'h010],
    [12'h020:12'h030], [12'h040:12'h048], 12'h060, 12'h064};
  wire rd_take = pready && !pwrite;
  wire wr_take = pready && pwrite && pstrb[0];
  wire ph2     = mode_ch[2] inside {[TMC_PHASE1:TMC_PHASE4]};
  wire gang    = mode_ch[3] inside {TMC_RSYNC_PWM,
    [TMC_CPWM_PEAK:TMC_CPWM_BOTH]};

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  a_ready_next: assert property (psel && !penable |=> pready)
    else $error("no ready one cycle after setup");
  a_err_unmapped: assert property (pready |-> pslverr == !mapped)
    else $error("error response does not match address map");
  a_mode_high_ones: assert property (
    rd_take && paddr <= `TMC_OFS_MODE4 && paddr[1:0] == 2'b00
    |-> prdata[7:6] == 2'b11)
    else $error("mode bits 7 and 6 not read as one");
  a_short_pair_zero: assert property (
    rd_take && paddr inside {`TMC_OFS_MODE1, `TMC_OFS_MODE2}
    |-> prdata[5:4] == 2'b00)
    else $error("pairing bits of a short channel not zero");
  a_ch2_phase_quiet: assert property (
    ph2 && $past(ph2) |-> count_tick[0] == 1'b0)
    else $error("channel 2 ticks while phase counting");
  a_ch4_follows: assert property (
    gang |-> mode_ch[4] == mode_ch[3])
    else $error("channel 4 does not follow channel 3");
  a_pair_d_buf: assert property (
    wr_take && paddr == `TMC_OFS_MODE0 && pwdata[5]
    |-> ##2 func_d[0] == TMC_IO_BUFFER)
    else $error("register D not a buffer after pairing");
  a_rsync_decode: assert property (
    wr_take && paddr == `TMC_OFS_MODE3 && pwdata[3:0] == 4'h8
    |-> ##2 mode_ch[3] == TMC_RSYNC_PWM)
    else $error("reset-synchronised mode not decoded");
endmodule

bind tmc_channel_cfg tmc_channel_cfg_checker u_chk (.clk_sys, .reset_n,
  .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
  .pslverr, .count_tick, .mode_ch, .func_d);

/* verification/tmc_pin_model.sv */
/*
  External count pin source for the timer channel configuration block.
  Assumes the pins are asynchronous to clk_sys; the bench enables each.
*/
module tmc_pin_model
#(
  parameter int HALF_NS = 43
)
(
  // Pulse enables, bit 0 pin a to bit 2 pin c
  input  logic [2:0] run,
  // External count pins
  output logic       ext_count_pin_a,
  output logic       ext_count_pin_b,
  output logic       ext_count_pin_c
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [2:0] pin_q = 3'h0;

  // Pins toggle while enabled and fall back low, so no stray edge is left
  always begin
    #HALF_NS;
    pin_q = run & ~pin_q;
  end
  assign {ext_count_pin_c, ext_count_pin_b, ext_count_pin_a} = pin_q;
endmodule

/* verification/tmc_channel_cfg_tb.sv */
/*
  Self-checking bench of the timer channel configuration block.
  Assumes the design, its package and tmc_pin_model are compiled first.
*/
module tmc_channel_cfg_tb
  import tmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk_sys = 1'b0;
  logic        reset_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready;
  logic        pslverr;
  logic        err;
  logic [2:0]  count_tick;
  logic [2:0]  run = 3'h0;
  logic [4:0]  init_lvl_a;
  logic [4:0]  init_lvl_b;
  logic [4:0]  init_lvl_c;
  logic [4:0]  init_lvl_d;
  wire         ext_count_pin_a;
  wire         ext_count_pin_b;
  wire         ext_count_pin_c;
  tmc_mode_t   mode_ch [5];
  tmc_io_t     func_a [5];
  tmc_io_t     func_b [5];
  tmc_io_t     func_c [5];
  tmc_io_t     func_d [5];
  int          n_fail = 0;
  int          comparisons = 0;
  int          cyc = 0;
  int          tk [3] = '{0, 0, 0};
  int          pe [3] = '{0, 0, 0};
  int          d [3];
  int          e [3];

  tmc_channel_cfg u_dut (.clk_sys, .reset_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb(4'hf), .prdata, .pready, .pslverr,
    .ext_count_pin_a, .ext_count_pin_b, .ext_count_pin_c, .count_tick,
    .mode_ch, .func_a, .func_b, .func_c, .func_d, .init_lvl_a,
    .init_lvl_b, .init_lvl_c, .init_lvl_d);

  tmc_pin_model u_pins (.run, .ext_count_pin_a, .ext_count_pin_b,
    .ext_count_pin_c);

  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    for (int k = 0; k < 3; k++) tk[k] += count_tick[k];
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      stop_test();
    end
  end
  always @(posedge ext_count_pin_a) pe[0]++;
  always @(posedge ext_count_pin_b) pe[1]++;
  always @(posedge ext_count_pin_c) pe[2]++;

  task automatic stop_test();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One APB transfer; the request stands until ready is sampled high
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) n_fail++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Decoded outputs follow one edge after the write edge
    @(posedge clk_sys);
    @(negedge clk_sys);
  endtask

  // Counts ticks and pin edges over n + 20 cycles, pins enabled for n
  task automatic window(input int n, input logic [2:0] r);
    int s [3];
    int q [3];
    @(negedge clk_sys);
    s = tk;
    q = pe;
    run = r;
    repeat (n) @(negedge clk_sys);
    run = 3'h0;
    repeat (20) @(negedge clk_sys);
    foreach (d[k]) begin
      d[k] = tk[k] - s[k];
      e[k] = pe[k] - q[k];
    end
  endtask

  logic [11:0] ofs [14] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h010,
    12'h020, 12'h024, 12'h028, 12'h02c, 12'h030, 12'h040, 12'h044,
    12'h048, 12'h060};
  logic [3:0]  mc [11] = '{4'h0, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7,
    4'h8, 4'hd, 4'he, 4'hf};
  tmc_mode_t   me [11] = '{TMC_NORMAL, TMC_PWM1, TMC_PWM2, TMC_PHASE1,
    TMC_PHASE2, TMC_PHASE3, TMC_PHASE4, TMC_RSYNC_PWM, TMC_CPWM_PEAK,
    TMC_CPWM_VALLEY, TMC_CPWM_BOTH};
  logic [7:0]  ioc [4] = '{8'h81, 8'h96, 8'ha3, 8'h44};
  tmc_io_t     fa [4] = '{TMC_IO_OUT0, TMC_IO_OUT1, TMC_IO_TOGGLE,
    TMC_IO_OFF};
  tmc_io_t     fb [4] = '{TMC_IO_CAP_RISE, TMC_IO_CAP_FALL,
    TMC_IO_CAP_BOTH, TMC_IO_OFF};
  int          dv [6] = '{1, 4, 16, 64, 256, 1024};
  int          dv2 [6] = '{1, 4, 16, 64, 1024, 1024};
  logic [2:0]  cs2 [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7, 3'h7};

  initial begin
    int ch;
    repeat (16) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    for (int i = 0; i < 14; i++) begin
      xfer(1'b0, ofs[i], 32'h0);
      chk("reset", rd, i < 5 ? 32'hc0 : 32'h0);
      if (i > 4 && i < 13) begin
        xfer(1'b1, ofs[i], 32'h90 + i);
        xfer(1'b0, ofs[i], 32'h0);
        chk("io rw", rd, 32'h90 + i);
      end
    end
    $display("reset and access test done");
    for (int i = 0; i < 11; i++) begin
      ch = mc[i][3] ? 3 : 1;
      xfer(1'b1, 12'(4 * ch), {28'h0, mc[i]});
      chk("mode", mode_ch[ch], me[i]);
      if (ch == 3) chk("gang", mode_ch[4], me[i]);
      xfer(1'b0, 12'h064, 32'h0);
      chk("status", rd, {31'h0, ch == 3});
    end
    xfer(1'b1, 12'h00c, 32'h0);
    xfer(1'b1, 12'h004, 32'h32);
    xfer(1'b0, 12'h004, 32'h0);
    chk("short mode", rd, 32'hc2);
    xfer(1'b1, 12'h000, 32'h33);
    xfer(1'b0, 12'h000, 32'h0);
    chk("full mode", rd, 32'hf3);
    xfer(1'b1, 12'h040, 32'h12);
    chk("buf c", func_c[0], TMC_IO_BUFFER);
    chk("buf d", func_d[0], TMC_IO_BUFFER);
    xfer(1'b1, 12'h000, 32'h0);
    chk("unbuf c", func_c[0], TMC_IO_OUT1);
    $display("mode test done");
    for (int i = 0; i < 4; i++) begin
      xfer(1'b1, 12'h024, {24'h0, ioc[i]});
      chk("func a", func_a[1], fa[i]);
      chk("func b", func_b[1], fb[i]);
      chk("level a", init_lvl_a[1], i % 2);
      chk("level b", init_lvl_b[1], i == 3);
    end
    xfer(1'b1, 12'h044, 32'h56);
    chk("func c", func_c[3], TMC_IO_OUT1);
    chk("func d", func_d[3], TMC_IO_OUT0);
    chk("level c", init_lvl_c[3], 1);
    chk("level d", init_lvl_d[3], 1);
    xfer(1'b0, 12'h050, 32'h0);
    chk("unmapped", {rd[30:0], err}, 32'h1);
    $display("io test done");
    for (int i = 0; i < 6; i++) begin
      xfer(1'b1, 12'h060, {23'h0, 3'(i), 3'(i), cs2[i]});
      window(1004, 3'h0);
      chk("tick2", d[0], 1024 / dv2[i]);
      chk("tick3", d[1], 1024 / dv[i]);
      chk("tick4", d[2], 1024 / dv[i]);
    end
    for (int j = 0; j < 3; j++) begin
      xfer(1'b1, 12'h060, {23'h0, 3'h7, 3'h6, 3'(4 + j)});
      window(100, 3'h7);
      chk("pin2", d[0], e[j]);
      chk("pin3", d[1], e[0]);
      chk("pin4", d[2], e[1]);
    end
    $display("clock select test done");
    xfer(1'b1, 12'h008, 32'h4);
    xfer(1'b1, 12'h060, 32'h0);
    window(1004, 3'h0);
    chk("phase quiet", d[0], 0);
    chk("div1", d[1], 1024);
    $display("phase test done");
    stop_test();
  end
endmodule
